/* dv/encidx_enc_model.sv */
// encidx_enc_model: quadrature encoder with index output, driven by tasks.
// assumes: called from the bench right after a rising edge of aclk.
`timescale 1ns/100ps
`default_nettype none
module encidx_enc_model (
    input  wire logic aclk,
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_n
);
    // ----------------------------------------
    // gray phase, b leads a when turning up
    // ----------------------------------------
    logic [1:0] ph = 2'h0;
    initial enc_n = 1'b1;
    assign enc_a = ph[1];
    assign enc_b = ph[0] ^ ph[1];

    // one quadrature step, 1 up or 3 down
    task automatic turn(input logic [1:0] d);
        @(posedge aclk);
        ph <= ph + d;
        repeat (8) @(posedge aclk);
    endtask

    // index level, then settle
    task automatic index(input logic v);
        @(posedge aclk);
        enc_n <= v;
        repeat (10) @(posedge aclk);
    endtask
endmodule // encidx_enc_model
`default_nettype wire

/* dv/encidx_top_asserts.sv */
// encidx_top_asserts: bus handshake and interrupt checks on the top ports.
// assumes: bound to encidx_top, single clock aclk.
`timescale 1ns/100ps
`default_nettype none
module encidx_top_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_read_latency:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rvalid late");
    a_write_latency:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("bvalid timing");
    a_read_done:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    a_write_done:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    a_aw_blocked:
    assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("aw open");
    a_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
    a_reset_quiet:
    assert property (!$past(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("busy after reset");
    a_irq_drop:
    assert property ($fell(irq) |-> s_axi_bvalid)
        else $error("irq fell without write");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_irq: cover property ($rose(irq));
endmodule // encidx_top_asserts
bind encidx_top encidx_top_asserts chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

/* dv/testbench.sv */
// testbench: register-level tests of the encoder index latch over axi4-lite.
// assumes: encidx_top with encidx_enc_model on the encoder pins.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("ERROR %s expected %h seen %h", nm, exp, got); \
        end \
    end
module testbench;
    localparam logic [7:0] MD = encidx_pkg::IDX_MODE, PS = encidx_pkg::IDX_POS;
    localparam logic [7:0] KC = encidx_pkg::IDX_CONST, ST = encidx_pkg::IDX_STATUS;
    localparam logic [7:0] LT = encidx_pkg::IDX_LATCH, MK = encidx_pkg::IDX_MASK;
    localparam logic [1:0] SE = encidx_pkg::RESP_SLVERR;
    logic        aclk;
    logic        aresetn;
    logic        awvalid;
    logic        awready;
    logic        wvalid;
    logic        wready;
    logic        bvalid;
    logic        bready;
    logic        arvalid;
    logic        arready;
    logic        rvalid;
    logic        rready;
    logic        enc_a;
    logic        enc_b;
    logic        enc_n;
    logic        irq;
    logic [9:0]  awaddr;
    logic [9:0]  araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    int          n_fail = 0;
    int          check_count = 0;

    encidx_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n), .irq(irq));
    encidx_enc_model enc (.aclk(aclk), .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n));

    // ----------------------------------------
    // bus tasks and closing
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf,
                      input logic [1:0] er = 2'h0);
        int t;
        awaddr <= {a, 2'h0};
        wdata <= d;
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'h7;
        t = 0;
        do begin
            @(posedge aclk);
            t++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && t < 200);
        bready <= 1'b0;
        `CHK("bresp", bresp, er)
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm,
                      input logic [1:0] er = 2'h0);
        int t;
        araddr <= {a, 2'h0};
        {arvalid, rready} <= 2'h3;
        t = 0;
        do begin
            @(posedge aclk);
            t++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && t < 200);
        rready <= 1'b0;
        `CHK(nm, rdata, e)
        `CHK("rresp", rresp, er)
        @(posedge aclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        wrap_up();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(MD, 32'h0, "mode");
        rd(PS, 32'h0, "pos");
        rd(KC, 32'h0001_0000, "const");
        rd(LT, 32'h0, "latch");
        wr(ST, 32'h1);
        rd(ST, 32'h0, "status");
        rd(MK, 32'h0, "mask");
        wr(MD, 32'hffff_ffff);
        rd(MD, 32'h0000_05ff, "mode");
        wr(LT, 32'h1, 4'hf, SE);
        rd(LT, 32'h0, "latch");
        rd(8'h10, 32'h0, "unmapped", SE);
        wr(MD, 32'h0);
        wr(PS, 32'h1234_5678);
        wr(PS, 32'h0000_00ff, 4'h1);
        rd(PS, 32'h1234_56ff, "pos");
        wr(PS, 32'hffff_fffe);
        repeat (3) enc.turn(2'h1);
        rd(PS, 32'h1, "pos");
        enc.turn(2'h3);
        rd(PS, 32'h0, "pos");
        wr(KC, 32'h0000_8000);
        repeat (2) enc.turn(2'h1);
        rd(PS, 32'h1, "pos");
        wr(KC, 32'h0000_1388);
        wr(MD, 32'h400);
        wr(PS, 32'h0);
        repeat (2) enc.turn(2'h1);
        rd(PS, 32'h1, "pos");
        wr(MD, 32'h0);
        wr(PS, 32'h0);
        repeat (2) enc.turn(2'h1);
        rd(PS, 32'h0, "pos");
        wr(KC, 32'h0001_0000);
        enc.index(1'b0);
        for (int e = 0; e < 4; e++) begin
            wr(MD, {24'h0, e[1:0], 6'h0c});
            enc.index(1'b0);
            wr(ST, 32'h1);
            enc.index(1'b1);
            rd(ST, {31'h0, e != 2}, "rise");
            wr(ST, 32'h1);
            enc.index(1'b0);
            rd(ST, {31'h0, e != 1}, "fall");
        end
        wr(MD, 32'h48);
        enc.index(1'b0);
        wr(ST, 32'h1);
        enc.index(1'b1);
        rd(ST, 32'h0, "status");
        enc.index(1'b0);
        rd(ST, 32'h1, "status");
        wr(MD, 32'h5c);
        wr(PS, 32'h7);
        enc.index(1'b1);
        rd(LT, 32'h7, "latch");
        enc.index(1'b0);
        wr(PS, 32'h9);
        enc.index(1'b1);
        rd(LT, 32'h9, "latch");
        rd(PS, 32'h9, "pos");
        enc.index(1'b0);
        wr(MD, 32'h15c);
        wr(PS, 32'h20);
        enc.index(1'b1);
        rd(LT, 32'h20, "latch");
        rd(PS, 32'h0, "pos");
        enc.index(1'b0);
        wr(MD, 32'h6c);
        wr(PS, 32'h5);
        enc.index(1'b1);
        enc.index(1'b0);
        wr(PS, 32'h6);
        enc.index(1'b1);
        enc.index(1'b0);
        rd(LT, 32'h5, "latch");
        wr(MD, 32'h56);
        wr(PS, 32'h3);
        enc.index(1'b1);
        rd(LT, 32'h5, "latch");
        enc.index(1'b0);
        enc.turn(2'h1);
        enc.index(1'b1);
        rd(LT, 32'h4, "latch");
        enc.index(1'b0);
        enc.turn(2'h1);
        enc.index(1'b1);
        rd(LT, 32'h4, "latch");
        enc.index(1'b0);
        wr(ST, 32'h1);
        wr(MK, 32'h1);
        `CHK("irq", irq, 1'b0)
        enc.turn(2'h3);
        enc.index(1'b1);
        `CHK("irq", irq, 1'b1)
        wr(ST, 32'h0);
        rd(ST, 32'h1, "status");
        wr(ST, 32'h1);
        rd(ST, 32'h0, "status");
        `CHK("irq", irq, 1'b0)
        wr(MK, 32'h0);
        enc.index(1'b0);
        enc.index(1'b1);
        `CHK("irq", irq, 1'b0)
        wrap_up();
    end
endmodule // testbench
`default_nettype wire

/* hw/encidx_pkg.sv */
// encidx_pkg: register map, field positions, reset values and constants
// of the encoder index latch block.
// assumes: 32-bit axi4-lite register access, one aligned word per register.
package encidx_pkg;

    // ----------------------------------------------------------------
    // register word indices and address width
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_MODE   = 8'h38;
    localparam logic [7:0] IDX_POS    = 8'h39;
    localparam logic [7:0] IDX_CONST  = 8'h3a;
    localparam logic [7:0] IDX_STATUS = 8'h3b;
    localparam logic [7:0] IDX_LATCH  = 8'h3c;
    localparam logic [7:0] IDX_MASK   = 8'h3d;
    localparam int         ADDR_W     = 10;

    // ----------------------------------------------------------------
    // encoder_mode fields
    // ----------------------------------------------------------------
    localparam int         B_POL_A    = 0;
    localparam int         B_POL_B    = 1;
    localparam int         B_POL_N    = 2;
    localparam int         B_SKIP_AB  = 3;
    localparam int         B_CONT     = 4;
    localparam int         B_ONCE     = 5;
    localparam int         B_EDGE_LO  = 6;
    localparam int         B_EDGE_HI  = 7;
    localparam int         B_CLR_POS  = 8;
    localparam int         B_DECIMAL  = 10;
    localparam logic [31:0] MODE_MASK = 32'h0000_05ff;

    // ----------------------------------------------------------------
    // status bits, reset values, prescaler moduli, responses
    // ----------------------------------------------------------------
    localparam int          B_EVENT     = 0;
    localparam logic [31:0] RST_MODE    = 32'h0000_0000;
    localparam logic [31:0] RST_POS     = 32'h0000_0000;
    localparam logic [31:0] RST_CONST   = 32'h0001_0000;
    localparam logic [31:0] RST_LATCH   = 32'h0000_0000;
    localparam logic [16:0] BIN_MOD     = 17'h1_0000;
    localparam logic [16:0] DEC_MOD     = 17'h0_2710;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // index sensitivity modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ENCIDX_LEVEL = 2'b00,
        ENCIDX_RISE  = 2'b01,
        ENCIDX_FALL  = 2'b10,
        ENCIDX_BOTH  = 2'b11
    } encidx_edge_t;

endpackage

/* hw/encidx_quad.sv */
// encidx_quad: pin synchronisers and quadrature decoder for a, b, index.
// assumes: encoder pins are asynchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module encidx_quad (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic enc_a,
    input  wire logic enc_b,
    input  wire logic enc_n,
    output logic      a_lvl,
    output logic      b_lvl,
    output logic      n_lvl,
    output logic      step,
    output logic      up
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [2:0] prev_r;
    logic       step_r;
    logic       up_r;
    logic       step_nxt;
    logic       up_nxt;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // one-step transitions only, direction from phase order
    always_comb begin
        step_nxt = sync_r[0] ^ prev_r[0] ^ sync_r[1] ^ prev_r[1];
        up_nxt   = prev_r[0] ^ sync_r[1];
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
            prev_r <= 3'h0;
            step_r <= 1'b0;
            up_r   <= 1'b0;
        end else begin
            meta_r <= {enc_n, enc_b, enc_a};
            sync_r <= meta_r;
            prev_r <= sync_r;
            step_r <= step_nxt;
            up_r   <= up_nxt;
        end
    end

    assign a_lvl = prev_r[0];
    assign b_lvl = prev_r[1];
    assign n_lvl = prev_r[2];
    assign step  = step_r;
    assign up    = up_r;
endmodule // encidx_quad
`default_nettype wire

/* hw/encidx_top.sv */
// encidx_top: quadrature position counter with index capture, axi4-lite slave.
// assumes: single clock aclk, synchronous active-low aresetn, async encoder pins.
//
// Overview of operation
// - mode bit 10 picks fraction divisor, clear 65536, set 10000.
// - mode bit 8 set makes an index capture also zero the position.
// - mode bits 7:6 pick level, active edge, inactive edge or both edges.
// - mode bit 5 captures only on first index event after writing it.
// - mode bit 4 captures on every index event.
// - bit 3 clear requires index, a and b levels all to match.
// - mode bit 2 gives index active level, 0 low, 1 high.
// - mode bit 1 gives required phase b level for an index event.
// - mode bit 0 gives required phase a level for an index event.
// - position is a signed 32-bit register, readable and writable.
// - each capture copies the position into a read-only latch register.
// - event flag bit 0 sets on each event, cleared by writing one.
// - increment constant is signed 16.16, resetting to exactly one.
`timescale 1ns/100ps
`default_nettype none
module encidx_top (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [encidx_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [encidx_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          enc_a,
    input  wire logic                          enc_b,
    input  wire logic                          enc_n,
    output logic                               irq
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [7:0] word_idx(input logic [encidx_pkg::ADDR_W-1:0] addr);
        return addr[encidx_pkg::ADDR_W-1:2];
    endfunction

    function automatic logic [47:0] acc_step(input logic [31:0] pos, input logic [15:0] frac,
                                             input logic [31:0] k, input logic dir_up,
                                             input logic dec);
        logic [16:0] md;
        logic [16:0] sum;
        logic        cy;
        logic [31:0] inc;
        md = dec ? encidx_pkg::DEC_MOD : encidx_pkg::BIN_MOD;
        if (dir_up) begin
            sum = {1'b0, frac} + {1'b0, k[15:0]};
            cy  = (sum >= md);
            if (cy) begin
                sum = sum - md;
            end
        end else begin
            cy  = (frac < k[15:0]);
            sum = {1'b0, frac} - {1'b0, k[15:0]};
            if (cy) begin
                sum = sum + md;
            end
        end
        inc = {{16{k[31]}}, k[31:16]} + {31'h0, cy};
        return {(dir_up ? pos + inc : pos - inc), sum[15:0]};
    endfunction

    // ----------------------------------------------------------------
    // synchroniser and quadrature decode
    // ----------------------------------------------------------------
    logic a_lvl;
    logic b_lvl;
    logic n_lvl;
    logic q_step;
    logic q_up;

    encidx_quad u_quad (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enc_a   (enc_a),
        .enc_b   (enc_b),
        .enc_n   (enc_n),
        .a_lvl   (a_lvl),
        .b_lvl   (b_lvl),
        .n_lvl   (n_lvl),
        .step    (q_step),
        .up      (q_up)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [encidx_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0]  wstrb_r, wstrb_nxt;
    logic        aw_hold_r, aw_hold_nxt;
    logic        w_hold_r, w_hold_nxt;
    logic        awready_r, awready_nxt;
    logic        wready_r, wready_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        arready_r, arready_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic [31:0] mode_r, mode_nxt;
    logic [31:0] pos_r, pos_nxt;
    logic [15:0] frac_r, frac_nxt;
    logic [31:0] const_r, const_nxt;
    logic [31:0] latch_r, latch_nxt;
    logic        status_r, status_nxt;
    logic        mask_r, mask_nxt;
    logic        armed_r, armed_nxt;
    logic        qual_r, qual_nxt;
    logic        irq_r, irq_nxt;

    logic        wr_fire;
    logic [7:0]  wr_idx;
    logic        ev;
    logic        capture;
    logic [47:0] stepped;
    logic [31:0] mode_w;
    encidx_pkg::encidx_edge_t edge_sel;

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    always_comb begin
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        wr_fire     = aw_hold_r && w_hold_r && !bvalid_r;
        wr_idx      = word_idx(awaddr_r);
        if (s_axi_awvalid && awready_r) begin
            awaddr_nxt  = s_axi_awaddr;
            aw_hold_nxt = 1'b1;
        end
        if (s_axi_wvalid && wready_r) begin
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
            w_hold_nxt = 1'b1;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_fire) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            case (wr_idx)
                encidx_pkg::IDX_MODE, encidx_pkg::IDX_POS, encidx_pkg::IDX_CONST,
                encidx_pkg::IDX_STATUS, encidx_pkg::IDX_MASK: bresp_nxt = encidx_pkg::RESP_OKAY;
                encidx_pkg::IDX_LATCH: bresp_nxt = encidx_pkg::RESP_SLVERR;
                default: bresp_nxt = encidx_pkg::RESP_SLVERR;
            endcase
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = encidx_pkg::RESP_OKAY;
            case (word_idx(s_axi_araddr))
                encidx_pkg::IDX_MODE:   rdata_nxt = mode_r;
                encidx_pkg::IDX_POS:    rdata_nxt = pos_r;
                encidx_pkg::IDX_CONST:  rdata_nxt = const_r;
                encidx_pkg::IDX_STATUS: rdata_nxt = {31'h0, status_r};
                encidx_pkg::IDX_LATCH:  rdata_nxt = latch_r;
                encidx_pkg::IDX_MASK:   rdata_nxt = {31'h0, mask_r};
                default: begin
                    rdata_nxt = 32'h0000_0000;
                    rresp_nxt = encidx_pkg::RESP_SLVERR;
                end
            endcase
        end
        awready_nxt = !aw_hold_nxt;
        wready_nxt  = !w_hold_nxt;
        arready_nxt = !rvalid_nxt;
    end

    // ----------------------------------------------------------------
    // encoder core
    // ----------------------------------------------------------------
    always_comb begin
        mode_nxt   = mode_r;
        pos_nxt    = pos_r;
        frac_nxt   = frac_r;
        const_nxt  = const_r;
        latch_nxt  = latch_r;
        mask_nxt   = mask_r;
        armed_nxt  = armed_r;
        edge_sel   = encidx_pkg::encidx_edge_t'(mode_r[encidx_pkg::B_EDGE_HI:encidx_pkg::B_EDGE_LO]);
        // qualify with a and b unless skipped
        qual_nxt   = (n_lvl == mode_r[encidx_pkg::B_POL_N])
                     && (mode_r[encidx_pkg::B_SKIP_AB]
                         || ((a_lvl == mode_r[encidx_pkg::B_POL_A])
                             && (b_lvl == mode_r[encidx_pkg::B_POL_B])));
        case (edge_sel)
            encidx_pkg::ENCIDX_LEVEL: ev = qual_nxt;
            encidx_pkg::ENCIDX_RISE:  ev = qual_nxt && !qual_r;
            encidx_pkg::ENCIDX_FALL:  ev = !qual_nxt && qual_r;
            encidx_pkg::ENCIDX_BOTH:  ev = qual_nxt != qual_r;
            default:                  ev = 1'b0;
        endcase
        capture = ev && (mode_r[encidx_pkg::B_CONT] || armed_r);
        stepped = acc_step(pos_r, frac_r, const_r, q_up, mode_r[encidx_pkg::B_DECIMAL]);
        if (q_step) begin
            pos_nxt  = stepped[47:16];
            frac_nxt = stepped[15:0];
        end
        if (capture) begin
            latch_nxt = pos_r;
            armed_nxt = 1'b0;
            if (mode_r[encidx_pkg::B_CLR_POS]) begin
                pos_nxt  = encidx_pkg::RST_POS;
                frac_nxt = 16'h0000;
            end
        end
        // event sets, write one clears, set wins
        status_nxt = (status_r && !(wr_fire && wr_idx == encidx_pkg::IDX_STATUS
                                   && wstrb_r[0] && wdata_r[encidx_pkg::B_EVENT])) || ev;
        // unused mode bits forced to zero
        mode_w = merge(mode_r, wdata_r, wstrb_r) & encidx_pkg::MODE_MASK;
        if (wr_fire) begin
            case (wr_idx)
                encidx_pkg::IDX_MODE: begin
                    mode_nxt = mode_w;
                    // arm on write with bit set
                    if (mode_w[encidx_pkg::B_ONCE]) begin
                        armed_nxt = 1'b1;
                    end
                end
                encidx_pkg::IDX_POS: begin
                    pos_nxt  = merge(pos_r, wdata_r, wstrb_r);
                    frac_nxt = 16'h0000;
                end
                encidx_pkg::IDX_CONST: const_nxt = merge(const_r, wdata_r, wstrb_r);
                encidx_pkg::IDX_MASK: begin
                    if (wstrb_r[0]) begin
                        mask_nxt = wdata_r[encidx_pkg::B_EVENT];
                    end
                end
                default: mode_nxt = mode_r;
            endcase
        end
        irq_nxt = status_nxt && mask_nxt;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= encidx_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= encidx_pkg::RESP_OKAY;
            mode_r    <= encidx_pkg::RST_MODE;
            pos_r     <= encidx_pkg::RST_POS;
            frac_r    <= 16'h0000;
            const_r   <= encidx_pkg::RST_CONST;
            latch_r   <= encidx_pkg::RST_LATCH;
            status_r  <= 1'b0;
            mask_r    <= 1'b0;
            armed_r   <= 1'b0;
            qual_r    <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            mode_r    <= mode_nxt;
            pos_r     <= pos_nxt;
            frac_r    <= frac_nxt;
            const_r   <= const_nxt;
            latch_r   <= latch_nxt;
            status_r  <= status_nxt;
            mask_r    <= mask_nxt;
            armed_r   <= armed_nxt;
            qual_r    <= qual_nxt;
            irq_r     <= irq_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign irq           = irq_r;

endmodule // encidx_top
`default_nettype wire
